/* File: hdl/lpmc_defines.svh */
// Register offsets, field positions, reset values and mode codes of the mode controller
`ifndef LPMC_DEFINES_SVH
`define LPMC_DEFINES_SVH

`define LPMC_OFF_STBY 12'h000
`define LPMC_OFF_OSC 12'h004
`define LPMC_OFF_SYS 12'h008
`define LPMC_OFF_IDLE 12'h00C
`define LPMC_OFF_WAKE 12'h010
`define LPMC_OFF_STAT 12'h014

`define LPMC_MODE_IDLE 3'h3
`define LPMC_MODE_SLEEP 3'h5
`define LPMC_MODE_STOP 3'h1

`define LPMC_STBY_MODE_LSB 0
`define LPMC_STBY_STOP_PIN_DRIVE_SELECT_BIT 16
`define LPMC_STBY_MODE_RST 3'h3
`define LPMC_STBY_STOP_PIN_DRIVE_SELECT_RST 1'h0

`define LPMC_OSC_WUSTART_BIT 0
`define LPMC_OSC_WUBUSY_BIT 1
`define LPMC_OSC_PLLON_BIT 2
`define LPMC_OSC_HSEN_BIT 8
`define LPMC_OSC_LSEN_BIT 9
`define LPMC_OSC_WUTIME_LSB 12
`define LPMC_OSC_WUSEL_BIT 16
`define LPMC_OSC_PLLON_RST 1'h0
`define LPMC_OSC_HSEN_RST 1'h1
`define LPMC_OSC_LSEN_RST 1'h0
`define LPMC_OSC_WUTIME_RST 3'h0
`define LPMC_OSC_WUSEL_RST 1'h0

`define LPMC_SYS_SLOW_BIT 0
`define LPMC_SYS_SLOW_RST 1'h0

`define LPMC_IDLE_EN_RST 7'h00

`define LPMC_WU_BASE_SHIFT 8

`endif

/* File: hdl/lpmc_pkg.sv */
// Types shared by the mode controller files
package lpmc_pkg;

    // Codes run 000, idle 001, stop 010, sleep 011, warm 110
    typedef enum logic [2:0] {
        LPMC_RUN = 3'h0,
        LPMC_IDLE = 3'h1,
        LPMC_STOP = 3'h2,
        LPMC_SLEEP = 3'h3,
        LPMC_WARM = 3'h6
    } lpmc_state_t;

    // Peripheral clock indices
    typedef enum int {
        LPMC_P_ADC = 0,
        LPMC_P_SIO = 1,
        LPMC_P_SBI = 2,
        LPMC_P_GENERAL_TIMER = 3,
        LPMC_P_WDT = 4,
        LPMC_P_CEC = 5,
        LPMC_P_RMC = 6
    } lpmc_periph_t;

endpackage : lpmc_pkg

/* File: hdl/lpmc_sync.sv */
// Two-flop synchroniser for asynchronous levels
module lpmc_sync #(
    parameter int W = 1
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [W-1:0] d, // Asynchronous level
    output logic [W-1:0] q // Synchronised level
);
    logic [W-1:0] meta_r;

    initial
    begin
        if (W < 1) $error("lpmc_sync: W must be at least 1");
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : lpmc_sync

/* File: hdl/lpmc_warmup.sv */
// Warm-up counter stepped by rising edges of the selected oscillator
`include "lpmc_defines.svh"
module lpmc_warmup #(
    parameter int CW = 16,
    parameter int BASE = `LPMC_WU_BASE_SHIFT
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic start, // Start pulse
    input wire logic tick, // Synchronised oscillator level
    input wire logic [2:0] time_sel, // Warm-up length select
    output logic busy, // Count running
    output logic done // One-cycle pulse at completion
);
    logic [CW-1:0] cnt_r;
    logic tick_d_r;
    logic busy_r;
    wire tick_rise = tick & ~tick_d_r;
    wire [CW-1:0] target = CW'(1) << (BASE + int'(time_sel));
    wire last = busy_r & tick_rise & (cnt_r == target - CW'(1));

    initial
    begin
        if (BASE + 7 >= CW) $error("lpmc_warmup: CW too small for BASE");
    end

    assign busy = busy_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= '0;
            tick_d_r <= 1'b0;
            busy_r <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            tick_d_r <= tick;
            done <= last;
            if (start)
            begin
                cnt_r <= '0;
                busy_r <= 1'b1;
            end
            else if (last)
                busy_r <= 1'b0;
            else if (busy_r && tick_rise)
                cnt_r <= cnt_r + CW'(1);
        end
    end
endmodule : lpmc_warmup

/* File: hdl/lpmc_ctrl.sv */
// Low power mode controller: APB registers, mode state machine, clock and pin gating
`include "lpmc_defines.svh"

// Operation
// - Mode field chosen by software; entry only on wait-for-interrupt request.
// - IDLE stops only the processor; peripherals without idle enable halt.
// - SLEEP keeps only low-speed osc, RTC, consumer link, remote preprocessor.
// - Release from SLEEP or STOP resumes the prior NORMAL or SLOW mode.
// - STOP halts all clocks and both oscillators.
// - STOP pins off with drive select 0, else follow own enables.
// - IDLE encodes as 011; only documented codes may be written; mode_r stores any code, and other codes stay in RUN on wfi.
// - SLOW gives no clock to converter, serial, bus, timers, watchdog.
// - SLOW leaves high-speed osc running; software clears its enable.
// - Interrupt, NMI or reset releases a mode, sources per mode.
// - Watchdog NMI releases only IDLE; NMI pin releases all modes.
// - Reset release returns NORMAL with every register at reset value.
// - STOP exit, or SLEEP exit to NORMAL, runs warm-up before clock.
// - SLOW-SLEEP-SLOW keeps low-speed osc and skips warm-up.
// - Warm-up counts selected oscillator for the three-bit time field.
module lpmc_ctrl
    import lpmc_pkg::*;
#(
    parameter int NIRQ = 8,
    parameter int NPORT = 16,
    parameter int WU_CW = 16
) (
    input wire logic pclk, // APB clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic wfi_req, // Wait-for-interrupt pulse from core
    input wire logic [NIRQ-1:0] irq_req, // Interrupt request levels
    input wire logic wdt_nmi_req, // Watchdog NMI level
    input wire logic nmi_pin, // External NMI pin
    input wire logic hs_osc_clk, // High-speed oscillator level
    input wire logic ls_osc_clk, // Low-speed oscillator level
    input wire logic [NPORT-1:0] port_input_enable, // Pin input enables
    input wire logic [NPORT-1:0] port_output_control, // Pin output enables
    output logic [NPORT-1:0] port_ie_eff, // Gated input enables
    output logic [NPORT-1:0] port_oe_eff, // Gated output enables
    output logic cpu_clk_en, // Processor clock gate
    output logic sys_clk_en, // System clock output gate
    output logic [6:0] periph_clk_en, // Peripheral clock gates
    output logic rtc_clk_en, // Real time clock gate
    output logic hs_osc_en, // High-speed oscillator run
    output logic ls_osc_en, // Low-speed oscillator run
    output logic pll_en, // PLL run
    output logic slow_active, // Low-speed system clock
    output logic wake_resume // Release handling may start
);
    logic [2:0] mode_r;
    logic stop_pin_drive_select_r;
    logic pll_on_r;
    logic hs_en_r;
    logic ls_en_r;
    logic [2:0] wu_time_r;
    logic wu_sel_r;
    logic slow_r;
    logic [6:0] idle_en_r;
    logic [NIRQ-1:0] wake_en_r;
    lpmc_state_t state_r;
    lpmc_state_t state_nxt;
    logic wake_r;
    logic wake_nxt;
    logic [1:0] osc_s;
    logic nmi_s;
    logic wu_busy;
    logic wu_done;

    initial
    begin
        if (NIRQ < 1 || NIRQ > 32) $error("lpmc_ctrl: NIRQ out of range");
        if (NPORT < 1) $error("lpmc_ctrl: NPORT must be positive");
    end

    // Clock gate per peripheral in each state
    function automatic logic periph_on(lpmc_state_t st, int idx, logic slow, logic idle_en);
        logic always_slow;
        always_slow = (idx == LPMC_P_CEC) || (idx == LPMC_P_RMC);
        unique case (st)
            LPMC_RUN: periph_on = always_slow || !slow;
            LPMC_IDLE: periph_on = idle_en && (always_slow || !slow);
            LPMC_SLEEP: periph_on = always_slow;
            default: periph_on = 1'b0;
        endcase
    endfunction : periph_on

    lpmc_sync #(.W(3)) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d({nmi_pin, ls_osc_clk, hs_osc_clk}),
        .q({nmi_s, osc_s})
    );

    // APB decode
    wire setup = psel & ~penable;
    wire wr = psel & penable & pwrite;
    wire hit_stby = paddr == `LPMC_OFF_STBY;
    wire hit_osc = paddr == `LPMC_OFF_OSC;
    wire hit_sys = paddr == `LPMC_OFF_SYS;
    wire hit_idle = paddr == `LPMC_OFF_IDLE;
    wire hit_wake = paddr == `LPMC_OFF_WAKE;
    wire hit_stat = paddr == `LPMC_OFF_STAT;
    wire mapped = hit_stby | hit_osc | hit_sys | hit_idle | hit_wake | hit_stat;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    wire [31:0] rd_stby = (32'(mode_r) << `LPMC_STBY_MODE_LSB) | (32'(stop_pin_drive_select_r) << `LPMC_STBY_STOP_PIN_DRIVE_SELECT_BIT);
    wire [31:0] rd_osc = (32'(wu_busy) << `LPMC_OSC_WUBUSY_BIT)
        | (32'(pll_on_r) << `LPMC_OSC_PLLON_BIT) | (32'(hs_en_r) << `LPMC_OSC_HSEN_BIT)
        | (32'(ls_en_r) << `LPMC_OSC_LSEN_BIT) | (32'(wu_time_r) << `LPMC_OSC_WUTIME_LSB)
        | (32'(wu_sel_r) << `LPMC_OSC_WUSEL_BIT);
    wire [31:0] rd_mux = hit_stby ? rd_stby
        : hit_osc ? rd_osc
        : hit_sys ? (32'(slow_r) << `LPMC_SYS_SLOW_BIT)
        : hit_idle ? 32'(idle_en_r)
        : hit_wake ? 32'(wake_en_r)
        : hit_stat ? 32'(state_r)
        : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (setup && !pwrite)
            prdata <= rd_mux;
    end

    // Register writes; reset returns every field to its reset value
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_r <= `LPMC_STBY_MODE_RST;
            stop_pin_drive_select_r <= `LPMC_STBY_STOP_PIN_DRIVE_SELECT_RST;
            pll_on_r <= `LPMC_OSC_PLLON_RST;
            hs_en_r <= `LPMC_OSC_HSEN_RST;
            ls_en_r <= `LPMC_OSC_LSEN_RST;
            wu_time_r <= `LPMC_OSC_WUTIME_RST;
            wu_sel_r <= `LPMC_OSC_WUSEL_RST;
            slow_r <= `LPMC_SYS_SLOW_RST;
            idle_en_r <= `LPMC_IDLE_EN_RST;
            wake_en_r <= '0;
        end
        else if (wr)
        begin
            if (hit_stby)
            begin
                mode_r <= pwdata[`LPMC_STBY_MODE_LSB +: 3];
                stop_pin_drive_select_r <= pwdata[`LPMC_STBY_STOP_PIN_DRIVE_SELECT_BIT];
            end
            if (hit_osc)
            begin
                pll_on_r <= pwdata[`LPMC_OSC_PLLON_BIT];
                hs_en_r <= pwdata[`LPMC_OSC_HSEN_BIT];
                ls_en_r <= pwdata[`LPMC_OSC_LSEN_BIT];
                wu_time_r <= pwdata[`LPMC_OSC_WUTIME_LSB +: 3];
                wu_sel_r <= pwdata[`LPMC_OSC_WUSEL_BIT];
            end
            if (hit_sys)
                slow_r <= pwdata[`LPMC_SYS_SLOW_BIT];
            if (hit_idle)
                idle_en_r <= pwdata[6:0];
            if (hit_wake)
                wake_en_r <= pwdata[NIRQ-1:0];
        end
    end

    // Release sources per mode
    wire irq_any = |irq_req;
    wire irq_deep = |(irq_req & wake_en_r);
    wire rel_idle = irq_any | wdt_nmi_req | nmi_s;
    wire rel_deep = irq_deep | nmi_s;
    wire sw_wu_start = wr & hit_osc & pwdata[`LPMC_OSC_WUSTART_BIT];
    wire warm_enter = (state_nxt == LPMC_WARM) && (state_r != LPMC_WARM);
    wire wu_tick = wu_sel_r ? osc_s[1] : osc_s[0];

    always_comb
    begin
        state_nxt = state_r;
        wake_nxt = 1'b0;
        unique case (state_r)
            LPMC_RUN:
            begin
                if (wfi_req)
                begin
                    unique case (mode_r)
                        `LPMC_MODE_IDLE: state_nxt = LPMC_IDLE;
                        `LPMC_MODE_SLEEP: state_nxt = LPMC_SLEEP;
                        `LPMC_MODE_STOP: state_nxt = LPMC_STOP;
                        default: state_nxt = LPMC_RUN;
                    endcase
                end
            end
            LPMC_IDLE:
            begin
                if (rel_idle)
                begin
                    state_nxt = LPMC_RUN;
                    wake_nxt = 1'b1;
                end
            end
            LPMC_SLEEP:
            begin
                if (rel_deep && slow_r)
                begin
                    state_nxt = LPMC_RUN;
                    wake_nxt = 1'b1;
                end
                else if (rel_deep)
                    state_nxt = LPMC_WARM;
            end
            LPMC_STOP:
            begin
                if (rel_deep)
                    state_nxt = LPMC_WARM;
            end
            LPMC_WARM:
            begin
                if (wu_done)
                begin
                    state_nxt = LPMC_RUN;
                    wake_nxt = 1'b1;
                end
            end
            default: state_nxt = LPMC_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= LPMC_RUN;
            wake_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            wake_r <= wake_nxt;
        end
    end

    lpmc_warmup #(.CW(WU_CW), .BASE(`LPMC_WU_BASE_SHIFT)) u_warmup (
        .clk(pclk),
        .rst_n(presetn),
        .start(warm_enter | sw_wu_start),
        .tick(wu_tick),
        .time_sel(wu_time_r),
        .busy(wu_busy),
        .done(wu_done)
    );

    // Clock, oscillator and pin gating; slow_r is untouched so prior mode resumes
    wire deep = (state_r == LPMC_SLEEP) || (state_r == LPMC_STOP);
    wire stopped = state_r == LPMC_STOP;
    assign cpu_clk_en = state_r == LPMC_RUN;
    assign sys_clk_en = (state_r == LPMC_RUN) || (state_r == LPMC_IDLE);
    assign rtc_clk_en = !stopped;
    assign hs_osc_en = hs_en_r && !deep;
    assign ls_osc_en = ls_en_r && !stopped;
    assign pll_en = pll_on_r && !slow_r && !deep;
    assign slow_active = slow_r;
    assign wake_resume = wake_r;
    assign port_ie_eff = (stopped && !stop_pin_drive_select_r) ? '0 : port_input_enable;
    assign port_oe_eff = (stopped && !stop_pin_drive_select_r) ? '0 : port_output_control;

    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++)
        begin : g_pclk
            assign periph_clk_en[gi] = periph_on(state_r, gi, slow_r, idle_en_r[gi]);
        end
    endgenerate

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_deep_release;
        (state_r == LPMC_STOP) && rel_deep;
    endsequence
    sequence s_warm_then_run;
        (state_r == LPMC_WARM) [*1] ##0 !cpu_clk_en;
    endsequence

    a_wfi_entry_only: assert property (
        (state_r == LPMC_RUN && !wfi_req) |=> state_r == LPMC_RUN)
        else $error("low power entered without wait request");
    a_idle_code: assert property (
        (state_r == LPMC_RUN && wfi_req && mode_r == 3'h3) |=> state_r == LPMC_IDLE)
        else $error("idle code did not enter idle");
    a_idle_gates: assert property (
        state_r == LPMC_IDLE |-> !cpu_clk_en && sys_clk_en
        && (periph_clk_en[LPMC_P_CEC] == idle_en_r[LPMC_P_CEC]))
        else $error("idle gating wrong");
    a_sleep_gates: assert property (
        state_r == LPMC_SLEEP |-> periph_clk_en == 7'h60 && rtc_clk_en && !hs_osc_en && !pll_en)
        else $error("sleep gating wrong");
    a_stop_all_off: assert property (
        state_r == LPMC_STOP |-> periph_clk_en == 7'h00 && !rtc_clk_en && !ls_osc_en
        && !hs_osc_en && !cpu_clk_en)
        else $error("stop left a clock running");
    a_stop_pins: assert property (
        (state_r == LPMC_STOP && !stop_pin_drive_select_r) |-> port_ie_eff == '0 && port_oe_eff == '0)
        else $error("pins enabled in stop");
    a_slow_no_periph: assert property (
        (state_r == LPMC_RUN && slow_r) |-> periph_clk_en[4:0] == 5'h00)
        else $error("slow mode fed a stopped peripheral");
    a_wdt_idle_only: assert property (
        (state_r == LPMC_STOP && wdt_nmi_req && !irq_deep && !nmi_s) |=> state_r == LPMC_STOP)
        else $error("watchdog nmi released stop");
    a_stop_warms: assert property (
        s_deep_release |=> s_warm_then_run)
        else $error("stop release skipped warm-up");
    a_slow_sleep_fast: assert property (
        (state_r == LPMC_SLEEP && slow_r && rel_deep)
        |=> state_r == LPMC_RUN && wake_resume ##1 !wake_resume)
        else $error("slow sleep release not immediate");
    a_warm_resume: assert property (
        (state_r == LPMC_WARM && wu_done) |=> cpu_clk_en && wake_r ##1 !wake_r)
        else $error("warm-up end did not resume");
    a_mode_kept: assert property (
        (state_r != LPMC_RUN) |-> $stable(slow_r) || $past(wr && hit_sys))
        else $error("prior mode lost during low power");
    a_irq_release: assert property (
        (state_r == LPMC_IDLE && irq_any) |=> state_r == LPMC_RUN)
        else $error("interrupt did not release idle");
endmodule : lpmc_ctrl

/* File: bench/lpmc_cpu_model.sv */
// Core-side model: wait requests and release sources
module lpmc_cpu_model (
    input wire logic pclk, // System clock
    input wire logic wake_resume, // Release handling may start
    output logic wfi_req, // Wait-for-interrupt pulse
    output logic [7:0] irq_req, // Interrupt levels
    output logic wdt_nmi_req, // Watchdog NMI level
    output logic nmi_pin // External NMI
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        wfi_req = 1'b0;
        irq_req = 8'h00;
        wdt_nmi_req = 1'b0;
        nmi_pin = 1'b0;
    end

    // Low power only via wait-for-interrupt, never via event or deep sleep
    task do_wfi();
        @(posedge pclk);
        wfi_req <= 1'b1;
        @(posedge pclk);
        wfi_req <= 1'b0;
    endtask : do_wfi

    task set_lv(input logic [7:0] v, input logic w);
        @(posedge pclk);
        irq_req <= v;
        wdt_nmi_req <= w;
    endtask : set_lv

    // One source only; level held until handling starts
    task hold(input int src, input int idx, output int cyc);
        cyc = 0;
        @(posedge pclk);
        if (src == 0)
            irq_req[idx] <= 1'b1;
        else if (src == 1)
            wdt_nmi_req <= 1'b1;
        else
            nmi_pin <= 1'b1;
        do
        begin
            @(negedge pclk);
            cyc++;
        end
        while (wake_resume !== 1'b1);
        @(posedge pclk);
        irq_req <= 8'h00;
        wdt_nmi_req <= 1'b0;
        nmi_pin <= 1'b0;
    endtask : hold
endmodule : lpmc_cpu_model

/* File: bench/lpmc_ctrl_tb.sv */
// Self-checking bench of the low power mode controller
`include "lpmc_defines.svh"
module lpmc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wfi_req, wdt_nmi_req, nmi_pin;
    logic hs_osc_clk, ls_osc_clk, cpu_clk_en, sys_clk_en, rtc_clk_en, hs_osc_en, ls_osc_en;
    logic pll_en, slow_active, wake_resume, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] irq_req;
    logic [15:0] pie, poc, ie_eff, oe_eff;
    logic [6:0] periph_clk_en;
    int n_mismatch, num_checks, tick, cyc;

    lpmc_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wfi_req(wfi_req), .irq_req(irq_req), .wdt_nmi_req(wdt_nmi_req),
        .nmi_pin(nmi_pin), .hs_osc_clk(hs_osc_clk), .ls_osc_clk(ls_osc_clk),
        .port_input_enable(pie), .port_output_control(poc), .port_ie_eff(ie_eff),
        .port_oe_eff(oe_eff), .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en),
        .periph_clk_en(periph_clk_en), .rtc_clk_en(rtc_clk_en), .hs_osc_en(hs_osc_en),
        .ls_osc_en(ls_osc_en), .pll_en(pll_en), .slow_active(slow_active),
        .wake_resume(wake_resume));

    lpmc_cpu_model i_cpu (.pclk(pclk), .wake_resume(wake_resume), .wfi_req(wfi_req),
        .irq_req(irq_req), .wdt_nmi_req(wdt_nmi_req), .nmi_pin(nmi_pin));

    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial
    begin
        hs_osc_clk = 1'b0;
        forever #37 hs_osc_clk = ~hs_osc_clk;
    end
    initial
    begin
        ls_osc_clk = 1'b0;
        forever #61 ls_osc_clk = ~ls_osc_clk;
    end

    task end_sim();
        $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    always @(posedge pclk)
    begin
        tick <= tick + 1;
        if (tick == 20000)
        begin
            n_mismatch++;
            end_sim();
        end
    end

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask : chk

    task chk_rng(input string nm, input int lo, input int hi, input int v);
        num_checks++;
        if (v < lo || v > hi)
        begin
            $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, v);
            n_mismatch++;
        end
    endtask : chk_rng

    task rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask : rchk

    // Gates: cpu sys rtc hs ls pll slow periph[6:0]
    task gchk(input logic [31:0] e);
        @(negedge pclk);
        chk("gates", e, {18'h0, cpu_clk_en, sys_clk_en, rtc_clk_en, hs_osc_en, ls_osc_en,
            pll_en, slow_active, periph_clk_en});
    endtask : gchk

    task do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        pie = 16'hA5C3;
        poc = 16'h3C5A;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        gchk(32'h3C7F);
        chk("ports", {pie, poc}, {ie_eff, oe_eff});
        rchk("stby", `LPMC_OFF_STBY, 32'h3);
        rchk("osc", `LPMC_OFF_OSC, 32'h100);
        rchk("sys", `LPMC_OFF_SYS, 32'h0);
        rchk("idle", `LPMC_OFF_IDLE, 32'h0);
        rchk("wake", `LPMC_OFF_WAKE, 32'h0);
        rchk("stat", `LPMC_OFF_STAT, 32'h0);
        rchk("unmapped", 12'h018, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        $display("test reset done");

        apb(1'b1, `LPMC_OFF_STBY, 32'h7);
        i_cpu.do_wfi();
        rchk("stat bad code", `LPMC_OFF_STAT, 32'h0);
        apb(1'b1, `LPMC_OFF_STBY, 32'h3);
        rchk("stat no wfi", `LPMC_OFF_STAT, 32'h0);
        $display("test entry done");

        apb(1'b1, `LPMC_OFF_IDLE, 32'h05);
        i_cpu.do_wfi();
        gchk(32'h1C05);
        rchk("stat idle", `LPMC_OFF_STAT, 32'h1);
        i_cpu.hold(1, 0, cyc);
        chk_rng("idle wake", 1, 4, cyc);
        i_cpu.do_wfi();
        i_cpu.hold(0, 3, cyc);
        chk_rng("idle irq wake", 1, 4, cyc);
        gchk(32'h3C7F);
        $display("test idle done");

        apb(1'b1, `LPMC_OFF_STBY, 32'h1);
        apb(1'b1, `LPMC_OFF_WAKE, 32'h01);
        i_cpu.do_wfi();
        gchk(32'h0000);
        chk("ports off", 32'h0, {ie_eff, oe_eff});
        i_cpu.set_lv(8'h02, 1'b1);
        repeat (20) @(posedge pclk);
        rchk("stat stop", `LPMC_OFF_STAT, 32'h2);
        i_cpu.set_lv(8'h00, 1'b0);
        fork
            i_cpu.hold(2, 0, cyc);
            begin
                repeat (60) @(posedge pclk);
                rchk("stat warm", `LPMC_OFF_STAT, 32'h6);
                rchk("osc busy", `LPMC_OFF_OSC, 32'h102);
                chk("cpu warm", 32'h0, {31'h0, cpu_clk_en});
            end
        join
        chk_rng("stop warm", 755, 790, cyc);
        gchk(32'h3C7F);
        $display("test stop done");

        apb(1'b1, `LPMC_OFF_STBY, 32'h10001);
        i_cpu.do_wfi();
        @(negedge pclk);
        chk("ports on", {pie, poc}, {ie_eff, oe_eff});
        i_cpu.hold(0, 0, cyc);
        chk_rng("stop irq warm", 755, 790, cyc);
        $display("test drive done");

        apb(1'b1, `LPMC_OFF_OSC, 32'h11301);
        rchk("osc sw warm", `LPMC_OFF_OSC, 32'h11302);
        apb(1'b1, `LPMC_OFF_STBY, 32'h5);
        i_cpu.do_wfi();
        gchk(32'h0A60);
        i_cpu.hold(0, 0, cyc);
        chk_rng("sleep warm", 2495, 2535, cyc);
        gchk(32'h3E7F);
        $display("test sleep done");

        apb(1'b1, `LPMC_OFF_SYS, 32'h1);
        gchk(32'h3EE0);
        i_cpu.do_wfi();
        gchk(32'h0AE0);
        i_cpu.hold(2, 0, cyc);
        chk_rng("slow wake", 1, 8, cyc);
        gchk(32'h3EE0);
        $display("test slow done");

        apb(1'b1, `LPMC_OFF_SYS, 32'h0);
        apb(1'b1, `LPMC_OFF_STBY, 32'h1);
        i_cpu.do_wfi();
        do_reset();
        gchk(32'h3C7F);
        rchk("stat rst", `LPMC_OFF_STAT, 32'h0);
        rchk("stby rst", `LPMC_OFF_STBY, 32'h3);
        rchk("osc rst", `LPMC_OFF_OSC, 32'h100);
        $display("test reset release done");
        end_sim();
    end
endmodule : lpmc_ctrl_tb
